// ---- rtl/cidfs_defines.vh ----
// Purpose: constants for the caller id fsk sequencer
// Assumes: 10 MHz system clock, 1200 baud line rate
// Notes: register addresses are word indices on the simple register port
`ifndef CIDFS_DEFINES_VH
`define CIDFS_DEFINES_VH

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define CIDFS_ADDR_FLAG_RUN_LENGTH 5'h13
`define CIDFS_ADDR_DATA_BYTE_COUNT 5'h14
`define CIDFS_ADDR_SEIZURE_PAIR_COUNT 5'h15
`define CIDFS_ADDR_MARK_RUN_LENGTH 5'h16
`define CIDFS_ADDR_GENERATOR_CONTROL 5'h17

// ------------------------------------------------------------
// generator_control fields and reset values
// ------------------------------------------------------------
`define CIDFS_BIT_TX_GO 0
`define CIDFS_BIT_HOLD_MARK_AFTER 1
`define CIDFS_BIT_TONE_STANDARD_SEL 2
`define CIDFS_BIT_GENERATOR_ON 3
`define CIDFS_FLD_CHANNEL_SEL_LO 4
`define CIDFS_FLD_CHANNEL_SEL_HI 5
`define CIDFS_RST_REG8 8'h00

// ------------------------------------------------------------
// byte store and timing
// ------------------------------------------------------------
`define CIDFS_STORE_DEPTH 7'h40
`define CIDFS_CLK_NS 100
`define CIDFS_BAUD_NS 833333
// divide by the clock period so the figure stays inside 32-bit integer arithmetic
`define CIDFS_BAUD_CYCLES (`CIDFS_BAUD_NS / `CIDFS_CLK_NS)

`endif

// ---- rtl/cidfs_baud_div.v ----
// Purpose: one-cycle baud strobe from the system clock
// Assumes: period of at least two cycles
// Notes: free running, so the first bit after a start may wait up to one period
`default_nettype none

module cidfs_baud_div #(
  parameter PERIOD = 8333
) (
  input wire mclk_i,
  input wire nrst_i,
  output reg strobe_o
);

  reg [15:0] count;

  // ----------------------------------------------------------
  // divider
  // ----------------------------------------------------------
  // count down and pulse on wrap
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      count <= 16'h0000;
      strobe_o <= 1'b0;
    end else if (count == 16'h0000) begin
      count <= PERIOD[15:0] - 16'h0001;
      strobe_o <= 1'b1;
    end else begin
      count <= count - 16'h0001;
      strobe_o <= 1'b0;
    end
  end

endmodule // cidfs_baud_div

`default_nettype wire

// ---- rtl/cidfs_top.v ----
// Purpose: caller id fsk sequencer with register file and 64 byte store
// Assumes: single clock, synchronous active low reset, same-clock register port
// Notes: bits leave on tx_bit_o one per baud strobe, tone choice is passed on
`include "cidfs_defines.vh"
`default_nettype none

// Function
// - after each byte send flag_bits ones, 0 to 255
// - send byte_count bytes per start, at most 64, beginning at store byte 0
// - seizure is repeated zero-then-one pairs, pair count from seizure_pairs
// - seizure length in bits is twice seizure_pairs, up to 510
// - after seizure send mark_bits ones, 0 to 255
// - writing tx_go starts sending; hardware clears it when all bytes are out
// - data done with hold_mark_after set keeps sending ones
// - data done with hold_mark_after clear mutes the output
// - tone_standard_sel 0 picks the 202 tone set, 1 the v.23 set
// - generator_on 0 disables the generator, 1 enables it
// - channel_sel routes the shared generator to one of four channels
// - each byte is start zero, eight data bits, stop one, flag run
// - bytes are serialised least significant bit first
// - re-setting a cleared hold_mark_after waits for the next start
module cidfs_top #(
  parameter BAUD_CYCLES = `CIDFS_BAUD_CYCLES
) (
  input wire mclk_i,
  input wire nrst_i,
  input wire reg_wr_i,
  input wire [4:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire store_wr_i,
  input wire [5:0] store_addr_i,
  input wire [7:0] store_wdata_i,
  output reg [7:0] store_rdata_o,
  output reg tx_bit_o,
  output reg tx_mute_o,
  output reg bit_strobe_o,
  output reg tone_standard_sel_o,
  output reg generator_on_o,
  output reg [3:0] chan_active_o,
  output reg busy_o
);

  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_SEIZ = 3'h1;
  localparam S_MARK = 3'h2;
  localparam S_NEXT = 3'h3;
  localparam S_START = 3'h4;
  localparam S_DATA = 3'h5;
  localparam S_STOP = 3'h6;
  localparam S_FLAG = 3'h7;

  reg [7:0] flag_bits;
  reg [7:0] byte_count;
  reg [7:0] seizure_pairs;
  reg [7:0] mark_bits;
  reg tx_go;
  reg hold_mark_after;
  reg tone_standard_sel;
  reg generator_on;
  reg [1:0] channel_sel;
  reg hold_armed;
  reg [7:0] callerid_byte_store [0:63];
  reg [2:0] state;
  reg [8:0] cnt;
  reg [6:0] byte_idx;
  reg [7:0] shreg;
  reg done_pulse;
  wire strobe;
  wire ctl_wr;
  wire [6:0] byte_limit;

  assign ctl_wr = reg_wr_i && (reg_addr_i == `CIDFS_ADDR_GENERATOR_CONTROL);
  // an out of range count is held at the store depth so the index never wraps
  assign byte_limit = (byte_count > {1'b0, `CIDFS_STORE_DEPTH}) ? `CIDFS_STORE_DEPTH : byte_count[6:0];

  cidfs_baud_div #(
    .PERIOD(BAUD_CYCLES)
  ) u_div (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .strobe_o(strobe)
  );

  // ----------------------------------------------------------
  // register file
  // ----------------------------------------------------------
  // software writes; hardware clear of tx_go loses to a same-cycle write of one
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      flag_bits <= `CIDFS_RST_REG8;
      byte_count <= `CIDFS_RST_REG8;
      seizure_pairs <= `CIDFS_RST_REG8;
      mark_bits <= `CIDFS_RST_REG8;
      tx_go <= 1'b0;
      hold_mark_after <= 1'b0;
      tone_standard_sel <= 1'b0;
      generator_on <= 1'b0;
      channel_sel <= 2'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `CIDFS_ADDR_FLAG_RUN_LENGTH) flag_bits <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `CIDFS_ADDR_DATA_BYTE_COUNT) byte_count <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `CIDFS_ADDR_SEIZURE_PAIR_COUNT) seizure_pairs <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `CIDFS_ADDR_MARK_RUN_LENGTH) mark_bits <= reg_wdata_i;
      if (ctl_wr) begin
        tx_go <= reg_wdata_i[`CIDFS_BIT_TX_GO];
        hold_mark_after <= reg_wdata_i[`CIDFS_BIT_HOLD_MARK_AFTER];
        tone_standard_sel <= reg_wdata_i[`CIDFS_BIT_TONE_STANDARD_SEL];
        generator_on <= reg_wdata_i[`CIDFS_BIT_GENERATOR_ON];
        channel_sel <= reg_wdata_i[`CIDFS_FLD_CHANNEL_SEL_HI:`CIDFS_FLD_CHANNEL_SEL_LO];
      end else if (done_pulse) begin
        tx_go <= 1'b0;
      end
    end
  end

  // read data registered one cycle after the address
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      case (reg_addr_i)
        `CIDFS_ADDR_FLAG_RUN_LENGTH: reg_rdata_o <= flag_bits;
        `CIDFS_ADDR_DATA_BYTE_COUNT: reg_rdata_o <= byte_count;
        `CIDFS_ADDR_SEIZURE_PAIR_COUNT: reg_rdata_o <= seizure_pairs;
        `CIDFS_ADDR_MARK_RUN_LENGTH: reg_rdata_o <= mark_bits;
        `CIDFS_ADDR_GENERATOR_CONTROL: reg_rdata_o <= {2'b00, channel_sel, generator_on,
                                                        tone_standard_sel, hold_mark_after, tx_go};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------
  // byte store
  // ----------------------------------------------------------
  // bytes are kept as written; bit order is fixed only at serialisation
  always @(posedge mclk_i) begin
    if (store_wr_i) begin
      callerid_byte_store[store_addr_i] <= store_wdata_i;
    end
  end

  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      store_rdata_o <= 8'h00;
    end else begin
      store_rdata_o <= callerid_byte_store[store_addr_i];
    end
  end

  // ----------------------------------------------------------
  // hold mark arming
  // ----------------------------------------------------------
  // armed at each start, dropped once software clears the bit; a start wins over a same-cycle clear
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      hold_armed <= 1'b0;
    end else if (state == S_IDLE && strobe && tx_go && generator_on) begin
      hold_armed <= 1'b1;
    end else if (ctl_wr && !reg_wdata_i[`CIDFS_BIT_HOLD_MARK_AFTER]) begin
      hold_armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  // zero-length phases are skipped on a plain clock so no bit period is spent
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      state <= S_IDLE;
      cnt <= 9'h000;
      byte_idx <= 7'h00;
      shreg <= 8'h00;
      tx_bit_o <= 1'b1;
      tx_mute_o <= 1'b1;
      bit_strobe_o <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      bit_strobe_o <= strobe;
      done_pulse <= 1'b0;
      if (!generator_on) begin
        state <= S_IDLE;
        tx_mute_o <= 1'b1;
        tx_bit_o <= 1'b1;
      end else begin
        case (state)
          S_IDLE: begin
            if (strobe) begin
              tx_bit_o <= 1'b1;
              tx_mute_o <= !(hold_armed && hold_mark_after);
              if (tx_go) begin
                state <= S_SEIZ;
                cnt <= 9'h000;
                byte_idx <= 7'h00;
              end
            end
          end
          S_SEIZ: begin
            if (seizure_pairs == 8'h00) begin
              state <= S_MARK;
            end else if (strobe) begin
              tx_bit_o <= cnt[0];
              tx_mute_o <= 1'b0;
              cnt <= cnt + 9'h001;
              if (cnt == {seizure_pairs, 1'b0} - 9'h001) begin
                state <= S_MARK;
                cnt <= 9'h000;
              end
            end
          end
          S_MARK: begin
            if (mark_bits == 8'h00) begin
              state <= S_NEXT;
            end else if (strobe) begin
              tx_bit_o <= 1'b1;
              tx_mute_o <= 1'b0;
              cnt <= cnt + 9'h001;
              if (cnt[7:0] == mark_bits - 8'h01) begin
                state <= S_NEXT;
                cnt <= 9'h000;
              end
            end
          end
          S_NEXT: begin
            if (byte_idx == byte_limit) begin
              state <= S_IDLE;
              done_pulse <= 1'b1;
            end else begin
              state <= S_START;
              shreg <= callerid_byte_store[byte_idx[5:0]];
            end
          end
          S_START: begin
            if (strobe) begin
              tx_bit_o <= 1'b0;
              tx_mute_o <= 1'b0;
              state <= S_DATA;
              cnt <= 9'h000;
            end
          end
          S_DATA: begin
            if (strobe) begin
              tx_bit_o <= shreg[cnt[2:0]];
              cnt <= cnt + 9'h001;
              if (cnt[2:0] == 3'h7) begin
                state <= S_STOP;
              end
            end
          end
          S_STOP: begin
            if (strobe) begin
              tx_bit_o <= 1'b1;
              state <= S_FLAG;
              cnt <= 9'h000;
              byte_idx <= byte_idx + 7'h01;
            end
          end
          S_FLAG: begin
            if (flag_bits == 8'h00) begin
              state <= S_NEXT;
            end else if (strobe) begin
              tx_bit_o <= 1'b1;
              cnt <= cnt + 9'h001;
              if (cnt[7:0] == flag_bits - 8'h01) begin
                state <= S_NEXT;
                cnt <= 9'h000;
              end
            end
          end
          default: begin
            state <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // outputs to the modulator and channels
  // ----------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!nrst_i) begin
      tone_standard_sel_o <= 1'b0;
      generator_on_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      tone_standard_sel_o <= tone_standard_sel;
      generator_on_o <= generator_on;
      busy_o <= (state != S_IDLE);
    end
  end

  // one-hot route of the shared generator
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      always @(posedge mclk_i) begin
        if (!nrst_i) begin
          chan_active_o[gi] <= 1'b0;
        end else begin
          chan_active_o[gi] <= generator_on && (channel_sel == gi);
        end
      end
    end
  endgenerate

endmodule // cidfs_top

`default_nettype wire

// ---- testbench/cidfs_line_model.sv ----
// Purpose: tone modulator on the selected channel transmit path
// Assumes: a bit is taken in the cycle that strobe_i is high
// Notes: muted periods are dropped, so the bench sees only bits sent on the line
`default_nettype none

module cidfs_line_model (
  input wire logic mclk_i,
  input wire logic tx_bit_i,
  input wire logic tx_mute_i,
  input wire logic strobe_i,
  input wire logic std_i,
  input wire logic [3:0] chan_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // tone choice and bit capture
  // ------------------------------------------------------------
  logic bits [$];
  int tone_hz;
  int chan_no;
  // mark and space tones per standard, silence while muted
  always_comb tone_hz = tx_mute_i ? 0 : tx_bit_i ? (std_i ? 1300 : 1200) : (std_i ? 2100 : 2200);
  // the generator is shared, so the lowest active channel takes the tones
  always_comb chan_no = chan_i[0] ? 0 : chan_i[1] ? 1 : chan_i[2] ? 2 : chan_i[3] ? 3 : -1;
  // one line bit per baud period
  always @(posedge mclk_i) begin
    if (strobe_i && !tx_mute_i) begin
      bits.push_back(tx_bit_i);
    end
  end
endmodule // cidfs_line_model

`default_nettype wire

// ---- testbench/cidfs_chk_asserts.sv ----
// Purpose: port level checks of the fsk sequencer line output
// Assumes: baud strobe exactly BAUD_CYCLES apart, at least 9 cycles
// Notes: seizure length must be nonzero for the first two bit checks
`default_nettype none

module cidfs_chk #(
  parameter int BAUD_CYCLES = 20
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic tx_bit_o,
  input wire logic tx_mute_o,
  input wire logic bit_strobe_o,
  input wire logic generator_on_o,
  input wire logic [3:0] chan_active_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // line output properties
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  property p_strobe; bit_strobe_o |=> !bit_strobe_o [*8]; endproperty
  a_strobe: assert property (p_strobe) else $error("bit strobe too close");
  property p_stands; !bit_strobe_o && generator_on_o && $past(generator_on_o) |-> $stable(tx_bit_o); endproperty
  a_stands: assert property (p_stands) else $error("line bit moved between strobes");
  property p_off; !generator_on_o ##1 !generator_on_o |-> tx_mute_o && tx_bit_o && chan_active_o == 4'h0; endproperty
  a_off: assert property (p_off) else $error("generator off but line active");
  property p_chan; generator_on_o ##1 generator_on_o |-> $onehot(chan_active_o); endproperty
  a_chan: assert property (p_chan) else $error("channel select not one hot");
  property p_unmute_on; !tx_mute_o |-> $past(generator_on_o); endproperty
  a_unmute_on: assert property (p_unmute_on) else $error("unmuted while disabled");
  property p_first_zero; $fell(tx_mute_o) |-> !tx_bit_o && bit_strobe_o; endproperty
  a_first_zero: assert property (p_first_zero) else $error("seizure does not open with zero");
  property p_second_one; $fell(tx_mute_o) |-> ##BAUD_CYCLES (bit_strobe_o && tx_bit_o); endproperty
  a_second_one: assert property (p_second_one) else $error("seizure pair not zero then one");
  property p_mute_ones; tx_mute_o |-> tx_bit_o; endproperty
  a_mute_ones: assert property (p_mute_ones) else $error("muted line not at mark");
  property p_held_ones; !busy_o && !tx_mute_o |-> tx_bit_o; endproperty
  a_held_ones: assert property (p_held_ones) else $error("held line not at mark");
endmodule // cidfs_chk

bind cidfs_top cidfs_chk #(.BAUD_CYCLES(BAUD_CYCLES)) u_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .tx_bit_o(tx_bit_o), .tx_mute_o(tx_mute_o), .bit_strobe_o(bit_strobe_o),
  .generator_on_o(generator_on_o), .chan_active_o(chan_active_o), .busy_o(busy_o));

`default_nettype wire

// ---- testbench/cidfs_top_tb.sv ----
// Purpose: self checking bench for the caller id fsk sequencer
// Assumes: baud period cut to 20 cycles so each message is short
// Notes: expected line streams are built here from the store bytes
`include "cidfs_defines.vh"
`default_nettype none

module cidfs_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BAUD = 20;
  localparam logic [4:0] CA = `CIDFS_ADDR_GENERATOR_CONTROL;
  typedef struct {int seiz; int mark; int flag; int n; int hold; int std; int ch; int len;} cidfs_row_t;
  // seizure, mark, flag, bytes, hold, standard, channel, line bits sent; byte counts stay in the store
  cidfs_row_t rows [4] = '{'{2, 3, 1, 2, 0, 0, 0, 29}, '{1, 0, 0, 1, 1, 1, 1, 12},
    '{3, 2, 4, 0, 0, 1, 2, 8}, '{1, 1, 0, 3, 0, 0, 3, 33}};
  logic [7:0] sb [4] = '{8'h3c, 8'h81, 8'h5a, 8'hf0};
  logic [4:0] la [4] = '{`CIDFS_ADDR_FLAG_RUN_LENGTH, `CIDFS_ADDR_DATA_BYTE_COUNT,
    `CIDFS_ADDR_SEIZURE_PAIR_COUNT, `CIDFS_ADDR_MARK_RUN_LENGTH};
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i;
  logic [4:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic store_wr_i;
  logic [5:0] store_addr_i;
  logic [7:0] store_wdata_i;
  wire [7:0] reg_rdata_o;
  wire [7:0] store_rdata_o;
  wire tx_bit_o;
  wire tx_mute_o;
  wire bit_strobe_o;
  wire tone_standard_sel_o;
  wire generator_on_o;
  wire [3:0] chan_active_o;
  wire busy_o;
  int n_fail = 0;
  int cmp_count = 0;
  logic exq [$];

  // free running system clock
  always #50 mclk_i = ~mclk_i;

  cidfs_top #(.BAUD_CYCLES(BAUD)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .store_wr_i(store_wr_i),
    .store_addr_i(store_addr_i), .store_wdata_i(store_wdata_i), .store_rdata_o(store_rdata_o),
    .tx_bit_o(tx_bit_o), .tx_mute_o(tx_mute_o), .bit_strobe_o(bit_strobe_o),
    .tone_standard_sel_o(tone_standard_sel_o), .generator_on_o(generator_on_o),
    .chan_active_o(chan_active_o), .busy_o(busy_o));

  cidfs_line_model u_line (.mclk_i(mclk_i), .tx_bit_i(tx_bit_o), .tx_mute_i(tx_mute_o),
    .strobe_i(bit_strobe_o), .std_i(tone_standard_sel_o), .chan_i(chan_active_o));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task step(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobe low for a full cycle between writes so no edge sees two writes merge
  task wr(logic [4:0] a, logic [7:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    step(1);
    reg_wr_i = 1'b0;
    step(1);
  endtask

  task rd(logic [4:0] a, logic [7:0] exp);
    reg_addr_i = a;
    step(2);
    chk(reg_rdata_o, exp);
  endtask

  function logic [7:0] cv(int go, int hold, int std, int gen, int ch);
    return {2'b00, ch[1:0], gen[0], std[0], hold[0], go[0]};
  endfunction

  task wait_busy(logic v, int lim);
    int k;
    k = 0;
    while (busy_o !== v) begin
      if (k == lim) begin
        chk(busy_o, v);
        stop_test();
      end
      step(1);
      k++;
    end
  endtask

  task build(cidfs_row_t r);
    exq.delete();
    repeat (r.seiz) begin
      exq.push_back(1'b0);
      exq.push_back(1'b1);
    end
    repeat (r.mark + 0) exq.push_back(1'b1);
    for (int b = 0; b < r.n; b++) begin
      exq.push_back(1'b0);
      for (int i = 0; i < 8; i++) exq.push_back(sb[b][i]);
      exq.push_back(1'b1);
      repeat (r.flag) exq.push_back(1'b1);
    end
  endtask

  task run(cidfs_row_t w);
    int v [4];
    v = '{w.flag, w.n, w.seiz, w.mark};
    for (int i = 0; i < 4; i++) begin
      wr(la[i], v[i][7:0]);
      rd(la[i], v[i][7:0]);
    end
    wr(CA, cv(0, w.hold, w.std, 1, w.ch));
    build(w);
    u_line.bits.delete();
    wr(CA, cv(1, w.hold, w.std, 1, w.ch));
    wait_busy(1'b1, 100);
    chk(chan_active_o, 4'h1 << w.ch);
    chk(tone_standard_sel_o, w.std[0]);
    chk(generator_on_o, 1'b1);
    chk(u_line.chan_no, w.ch);
    wait_busy(1'b0, 20000);
    step(3 * BAUD);
    rd(CA, cv(0, w.hold, w.std, 1, w.ch));
    chk(w.hold ? u_line.bits.size() > w.len : u_line.bits.size() == w.len, 1);
    foreach (u_line.bits[i]) chk(u_line.bits[i], i < exq.size() ? exq[i] : 1'b1);
    if (w.hold) begin
      chk(u_line.tone_hz, w.std ? 1300 : 1200);
      wr(CA, cv(0, 0, w.std, 1, w.ch));
      step(2 * BAUD);
      chk(tx_mute_o, 1);
      wr(CA, cv(0, 1, w.std, 1, w.ch));
      step(2 * BAUD);
      chk(tx_mute_o, 1);
    end
    wr(CA, cv(0, 0, w.std, 0, w.ch));
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    // both buses idle from time zero so reset sees no stray write
    reg_wr_i = 1'b0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 8'h00;
    store_wr_i = 1'b0;
    store_addr_i = 6'h00;
    store_wdata_i = 8'h00;
    step(12);
    nrst_i = 1'b1;
    store_wr_i = 1'b1;
    for (int b = 0; b < 4; b++) begin
      store_addr_i = b[5:0];
      store_wdata_i = sb[b];
      step(1);
    end
    store_wr_i = 1'b0;
    store_addr_i = 6'h01;
    step(2);
    chk(store_rdata_o, sb[1]);
    foreach (rows[r]) run(rows[r]);
    // a start written while disabled must wait for the enable
    wr(CA, 8'h01);
    step(3 * BAUD);
    chk(busy_o, 0);
    chk(tx_mute_o, 1);
    rd(CA, 8'h01);
    wr(5'h00, 8'hff);
    rd(5'h00, 8'h00);
    wr(CA, 8'h09);
    wait_busy(1'b1, 100);
    // reset in mid send clears every register and silences the line
    nrst_i = 1'b0;
    step(12);
    chk({busy_o, tx_mute_o, tx_bit_o}, 3'b011);
    nrst_i = 1'b1;
    for (int i = 0; i < 4; i++) rd(la[i], `CIDFS_RST_REG8);
    rd(CA, `CIDFS_RST_REG8);
    stop_test();
  end
endmodule // cidfs_top_tb

`default_nettype wire
